// [pts_client.sv]
// client timing model: transmit words with stamp controls, receive words, both timers
// assumes the testbench calls its tasks and the port samples on the rising core_clk edge
`timescale 1ns/1ps
module pts_client (
    input wire logic core_clk,
    output logic tx_in_valid,
    output logic tx_in_sop,
    output logic tx_in_eop,
    output logic [pts_pkg::DATA_W-1:0] tx_in_data,
    output logic [1:0] tx_stamp_operation,
    output logic [pts_pkg::TAG_W-1:0] tx_tag_in,
    output logic tx_upd_chksum_in,
    output logic [pts_pkg::OFS_W-1:0] tx_ts_offset_in,
    output logic [pts_pkg::OFS_W-1:0] tx_ck_offset_in,
    output logic [pts_pkg::LANE_W-1:0] tx_sop_lane_in,
    output logic [pts_pkg::STAMP_W-1:0] tx_system_timer,
    output logic rx_in_valid,
    output logic rx_in_sop,
    output logic [pts_pkg::LANE_W-1:0] rx_sop_lane_in,
    output logic [pts_pkg::STAMP_W-1:0] rx_system_timer
);
    initial begin
        tx_in_valid = 1'b0;
        tx_in_sop = 1'b0;
        tx_in_eop = 1'b0;
        tx_in_data = 64'h0;
        tx_stamp_operation = 2'h0;
        tx_tag_in = 16'h0;
        tx_upd_chksum_in = 1'b0;
        tx_ts_offset_in = 16'h0;
        tx_ck_offset_in = 16'h0;
        tx_sop_lane_in = 2'h0;
        tx_system_timer = {48'h1, 32'h0};
        rx_in_valid = 1'b0;
        rx_in_sop = 1'b0;
        rx_sop_lane_in = 2'h0;
        rx_system_timer = 80'h0;
    end
    // normal mode timer: seconds above, nanoseconds below
    always @(posedge core_clk) tx_system_timer <= tx_system_timer + {48'h1, 32'h28};
    // transparent mode timer: bit 63 zero, nanoseconds 62:16, fraction 15:0
    always @(posedge core_clk) begin
        rx_system_timer <= {16'h0, 1'b0, rx_system_timer[62:0] + 63'h28_8000};
    end
    // one transmit word; controls stand with the start_of_packet word
    task automatic tx_word(input logic sop, input logic eop, input logic [1:0] op,
                           input logic [15:0] tag, input logic upd, input logic [15:0] tso,
                           input logic [15:0] cko, input logic [1:0] lane,
                           input logic [63:0] data, output logic [79:0] stamp);
        @(posedge core_clk);
        #1;
        stamp = tx_system_timer;
        tx_in_valid = 1'b1;
        tx_in_sop = sop;
        tx_in_eop = eop;
        tx_in_data = data;
        tx_stamp_operation = op;
        tx_tag_in = tag;
        tx_upd_chksum_in = upd;
        tx_ts_offset_in = tso;
        tx_ck_offset_in = cko;
        tx_sop_lane_in = lane;
    endtask
    // released lines are inverted on each idle word, so a second idle word shows the last word again
    task automatic tx_idle();
        @(posedge core_clk);
        #1;
        tx_in_valid = 1'b0;
        tx_in_sop = 1'b0;
        tx_in_eop = 1'b0;
        tx_in_data = ~tx_in_data;
        tx_stamp_operation = ~tx_stamp_operation;
        tx_tag_in = ~tx_tag_in;
        tx_upd_chksum_in = ~tx_upd_chksum_in;
        tx_ts_offset_in = ~tx_ts_offset_in;
        tx_ck_offset_in = ~tx_ck_offset_in;
        tx_sop_lane_in = ~tx_sop_lane_in;
    endtask
    task automatic rx_word(input logic sop, input logic [1:0] lane, output logic [79:0] stamp);
        @(posedge core_clk);
        #1;
        stamp = rx_system_timer;
        rx_in_valid = 1'b1;
        rx_in_sop = sop;
        rx_sop_lane_in = lane;
    endtask
    task automatic rx_idle();
        @(posedge core_clk);
        #1;
        rx_in_valid = 1'b0;
        rx_in_sop = 1'b0;
        rx_sop_lane_in = ~rx_sop_lane_in;
    endtask
endmodule

// [pts_frame_if.sv]
// per-frame one-step insertion controls between the port and its inserter
// driven on the core clock by the port top
`timescale 1ns/1ps
interface pts_frame_if;
    logic insert_en;
    logic upd_chksum;
    logic [pts_pkg::OFS_W-1:0] ts_offset;
    logic [pts_pkg::OFS_W-1:0] ck_offset;
    logic [pts_pkg::STAMP_W-1:0] stamp;
    modport src (output insert_en, output upd_chksum, output ts_offset, output ck_offset,
                 output stamp);
    modport sink (input insert_en, input upd_chksum, input ts_offset, input ck_offset,
                  input stamp);
endinterface

// [pts_one_step.sv]
// one-step inserter: writes the stamp into the frame and clears the checksum
// assumes frame controls are valid from the start-of-packet word onward
`timescale 1ns/1ps
module pts_one_step #(
    parameter bit ONE_STEP_EN = 1'b1
) (
    input wire logic core_clk,
    input wire logic rst_n,
    pts_frame_if.sink ctl,
    input wire logic in_valid,
    input wire logic in_sop,
    input wire logic in_eop,
    input wire logic [pts_pkg::DATA_W-1:0] in_data,
    output logic out_valid,
    output logic out_sop,
    output logic out_eop,
    output logic [pts_pkg::DATA_W-1:0] out_data
);
    pts_pkg::pts_frame_state_t state_q;
    logic [pts_pkg::WORD_W-1:0] word_q;
    logic [pts_pkg::WORD_W-1:0] word_cur;
    logic [pts_pkg::DATA_W-1:0] data_d;
    logic [pts_pkg::OFS_W-1:0] pos;
    logic [pts_pkg::OFS_W-1:0] rel;
    logic in_frame;

    // word index within the frame
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            state_q <= pts_pkg::PTS_IDLE;
            word_q <= pts_pkg::WORD_RST;
        end else if (in_valid) begin
            case (state_q)
                pts_pkg::PTS_IDLE: begin
                    if (in_sop && !in_eop) begin
                        state_q <= pts_pkg::PTS_IN_FRAME;
                    end
                end
                pts_pkg::PTS_IN_FRAME: begin
                    if (in_eop) begin
                        state_q <= pts_pkg::PTS_IDLE;
                    end
                end
                default: state_q <= pts_pkg::PTS_IDLE;
            endcase
            word_q <= word_cur + 13'h1;
        end
    end

    assign word_cur = in_sop ? pts_pkg::WORD_RST : word_q;
    // only bytes of a frame are replaced; idle words between frames pass untouched unless in_sop is high, as in_valid is not checked
    assign in_frame = in_sop || (state_q == pts_pkg::PTS_IN_FRAME);

    // byte replacement
    always_comb begin
        data_d = in_data;
        pos = 16'h0;
        rel = 16'h0;
        for (int i = 0; i < pts_pkg::DATA_BYTES; i++) begin
            pos = {word_cur, 3'(i)};
            rel = pos - ctl.ts_offset;
            if (ONE_STEP_EN && ctl.insert_en && in_frame) begin
                if (pts_pkg::pts_in_window(pos, ctl.ts_offset, 16'(pts_pkg::STAMP_BYTES))) begin
                    data_d[8*i +: 8] = pts_pkg::pts_stamp_byte(ctl.stamp, rel[3:0]);
                end
                if (ctl.upd_chksum &&
                    pts_pkg::pts_in_window(pos, ctl.ck_offset, 16'(pts_pkg::CK_BYTES))) begin
                    data_d[8*i +: 8] = pts_pkg::CK_FILL;
                end
            end
        end
    end

    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            out_valid <= 1'b0;
            out_sop <= 1'b0;
            out_eop <= 1'b0;
            out_data <= '0;
        end else begin
            out_valid <= in_valid;
            out_sop <= in_valid && in_sop;
            out_eop <= in_valid && in_eop;
            out_data <= data_d;
        end
    end

    default clocking cb @(posedge core_clk);
    endclocking
    default disable iff (!rst_n);

    property p_insert_first;
        (ONE_STEP_EN && in_valid && in_sop && ctl.insert_en && ctl.ts_offset == 16'h0 &&
         !(ctl.upd_chksum && ctl.ck_offset == 16'h0)) |=>
            (out_data[7:0] == $past(ctl.stamp[79:72]));
    endproperty
    a_insert_first: assert property (p_insert_first) else $error("stamp not inserted");

    property p_no_insert;
        (!ONE_STEP_EN || !ctl.insert_en) |=> (out_data == $past(in_data));
    endproperty
    a_no_insert: assert property (p_no_insert) else $error("frame modified");
endmodule

// [pts_pkg.sv]
// constants, field layouts and helpers shared by the timestamp port
// assumes one core clock for the transmit and receive sides
package pts_pkg;
    localparam int STAMP_W = 80;
    localparam int STAMP_BYTES = 10;
    localparam int TAG_W = 16;
    localparam int OFS_W = 16;
    localparam int LANE_W = 2;
    localparam int LANES = 4;
    localparam int FILL_W = 7;
    localparam int DATA_W = 64;
    localparam int DATA_BYTES = 8;
    localparam int CK_BYTES = 2;
    localparam int WORD_W = 13;
    localparam int BYTE_IDX_W = 3;

    // per-frame operation codes
    localparam logic [1:0] OP_NONE = 2'h0;
    localparam logic [1:0] OP_ONE_STEP = 2'h1;
    localparam logic [1:0] OP_TWO_STEP = 2'h2;
    localparam logic [1:0] OP_RSVD = 2'h3;

    // normal clock mode layout
    localparam int SEC_LSB = 32;
    localparam int NS_MSB = 31;
    // transparent clock mode layout
    localparam int TC_ZERO_BIT = 63;
    localparam int TC_NS_LSB = 16;
    localparam int TC_FRAC_MSB = 15;

    localparam logic [STAMP_W-1:0] STAMP_RST = 80'h0;
    localparam logic [TAG_W-1:0] TAG_RST = 16'h0;
    localparam logic [OFS_W-1:0] OFS_RST = 16'h0;
    localparam logic [LANE_W-1:0] LANE_RST = 2'h0;
    localparam logic [WORD_W-1:0] WORD_RST = 13'h0;
    localparam logic [7:0] CK_FILL = 8'h00;

    typedef enum logic {PTS_IDLE, PTS_IN_FRAME} pts_frame_state_t;

    // one-step and two-step frames take a stamp; reserved acts as none
    function automatic logic pts_takes_stamp(input logic [1:0] op);
        return (op == OP_ONE_STEP) || (op == OP_TWO_STEP);
    endfunction

    // byte k of a stamp, most significant byte first on the wire
    function automatic logic [7:0] pts_stamp_byte(input logic [STAMP_W-1:0] s,
                                                  input logic [3:0] k);
        logic [STAMP_W-1:0] t;
        t = s >> (8 * (STAMP_BYTES - 1 - int'(k)));
        return t[7:0];
    endfunction

    // byte position inside a window of len bytes starting at base
    function automatic logic pts_in_window(input logic [OFS_W-1:0] pos,
                                           input logic [OFS_W-1:0] base,
                                           input logic [OFS_W-1:0] len);
        logic [OFS_W-1:0] d;
        d = pos - base;
        return (pos >= base) && (d < len);
    endfunction
endpackage

// [pts_port.sv]
// timestamping port of a 40/50G MAC: transmit tag and stamp return,
// one-step insertion, receive stamp with lane index and aligner fill levels
// assumes the timers, streams and lane strobes are all on core_clk
`timescale 1ns/1ps

module pts_port #(
    parameter bit ONE_STEP_EN = 1'b1,
    parameter int LANES = pts_pkg::LANES,
    parameter int FILL_W = pts_pkg::FILL_W
) (
    input wire logic core_clk,
    input wire logic rst_n,
    input wire logic tx_in_valid,
    input wire logic tx_in_sop,
    input wire logic tx_in_eop,
    input wire logic [pts_pkg::DATA_W-1:0] tx_in_data,
    input wire logic [1:0] tx_stamp_operation,
    input wire logic [pts_pkg::TAG_W-1:0] tx_tag_in,
    input wire logic tx_upd_chksum_in,
    input wire logic [pts_pkg::OFS_W-1:0] tx_ts_offset_in,
    input wire logic [pts_pkg::OFS_W-1:0] tx_ck_offset_in,
    input wire logic [pts_pkg::LANE_W-1:0] tx_sop_lane_in,
    input wire logic [pts_pkg::STAMP_W-1:0] tx_system_timer,
    output logic tx_out_valid,
    output logic tx_out_sop,
    output logic tx_out_eop,
    output logic [pts_pkg::DATA_W-1:0] tx_out_data,
    output logic tx_stamp_valid,
    output logic [pts_pkg::TAG_W-1:0] tx_stamp_tag,
    output logic [pts_pkg::STAMP_W-1:0] tx_stamp,
    output logic [pts_pkg::LANE_W-1:0] tx_pcslane,
    input wire logic rx_in_valid,
    input wire logic rx_in_sop,
    input wire logic [pts_pkg::LANE_W-1:0] rx_sop_lane_in,
    input wire logic [pts_pkg::STAMP_W-1:0] rx_system_timer,
    output logic rx_out_valid,
    output logic rx_out_sop,
    output logic [pts_pkg::STAMP_W-1:0] rx_stamp,
    output logic [pts_pkg::LANE_W-1:0] rx_pcslane,
    input wire logic [LANES-1:0] lane_fill_push,
    input wire logic [LANES-1:0] lane_fill_pop,
    output logic [LANES-1:0][FILL_W-1:0] rx_lane_fill
);
    if (LANES < 1 || LANES > (1 << pts_pkg::LANE_W)) begin : g_chk_lanes
        $error("lane count not served by the lane index");
    end
    if (FILL_W < 1) begin : g_chk_fill
        $error("fill width must be positive");
    end

    logic tx_sop_now;
    logic stamp_req;
    logic ins_q;
    logic upd_q;
    logic [pts_pkg::OFS_W-1:0] ts_off_q;
    logic [pts_pkg::OFS_W-1:0] ck_off_q;
    logic [pts_pkg::STAMP_W-1:0] frame_stamp_q;
    logic ins_now;

    pts_frame_if frame_ctl ();

    assign tx_sop_now = tx_in_valid && tx_in_sop;
    // reserved code falls through to no stamp
    assign stamp_req = tx_sop_now && pts_pkg::pts_takes_stamp(tx_stamp_operation);
    assign ins_now = ONE_STEP_EN && (tx_stamp_operation == pts_pkg::OP_ONE_STEP);

    // frame controls held from the start-of-packet word to the frame end
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            ins_q <= 1'b0;
            upd_q <= 1'b0;
            ts_off_q <= pts_pkg::OFS_RST;
            ck_off_q <= pts_pkg::OFS_RST;
            frame_stamp_q <= pts_pkg::STAMP_RST;
        end else if (tx_sop_now) begin
            ins_q <= ins_now;
            upd_q <= tx_upd_chksum_in;
            ts_off_q <= tx_ts_offset_in;
            ck_off_q <= tx_ck_offset_in;
            frame_stamp_q <= tx_system_timer;
        end
    end

    assign frame_ctl.insert_en = tx_sop_now ? ins_now : ins_q;
    assign frame_ctl.upd_chksum = tx_sop_now ? tx_upd_chksum_in : upd_q;
    assign frame_ctl.ts_offset = tx_sop_now ? tx_ts_offset_in : ts_off_q;
    assign frame_ctl.ck_offset = tx_sop_now ? tx_ck_offset_in : ck_off_q;
    assign frame_ctl.stamp = tx_sop_now ? tx_system_timer : frame_stamp_q;

    pts_one_step #(
        .ONE_STEP_EN(ONE_STEP_EN)
    ) u_one_step (
        .core_clk(core_clk),
        .rst_n(rst_n),
        .ctl(frame_ctl),
        .in_valid(tx_in_valid),
        .in_sop(tx_in_sop),
        .in_eop(tx_in_eop),
        .in_data(tx_in_data),
        .out_valid(tx_out_valid),
        .out_sop(tx_out_sop),
        .out_eop(tx_out_eop),
        .out_data(tx_out_data)
    );

    // transmit stamp return, aligned with the outgoing start_of_packet
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            tx_stamp_valid <= 1'b0;
        end else begin
            tx_stamp_valid <= stamp_req;
        end
    end

    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            tx_stamp_tag <= pts_pkg::TAG_RST;
            tx_stamp <= pts_pkg::STAMP_RST;
        end else if (stamp_req) begin
            // no-operation frames never load the tag
            tx_stamp_tag <= tx_tag_in;
            // timer bits copied as given, in either clock mode
            tx_stamp <= tx_system_timer;
        end
    end

    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            tx_pcslane <= pts_pkg::LANE_RST;
        end else if (tx_sop_now) begin
            tx_pcslane <= tx_sop_lane_in;
        end
    end

    // receive side
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            rx_out_valid <= 1'b0;
            rx_out_sop <= 1'b0;
        end else begin
            rx_out_valid <= rx_in_valid;
            rx_out_sop <= rx_in_valid && rx_in_sop;
        end
    end

    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            rx_stamp <= pts_pkg::STAMP_RST;
            rx_pcslane <= pts_pkg::LANE_RST;
        end else if (rx_in_valid && rx_in_sop) begin
            rx_stamp <= rx_system_timer;
            rx_pcslane <= rx_sop_lane_in;
        end
    end

    // alignment buffer fill, one count per serdes cycle of skew
    function automatic logic [FILL_W-1:0] fill_next(input logic [FILL_W-1:0] f,
                                                    input logic push,
                                                    input logic pop);
        logic [FILL_W-1:0] r;
        r = f;
        if (push && !pop && f != {FILL_W{1'b1}}) begin
            r = f + 1'b1;
        end else if (pop && !push && f != '0) begin
            r = f - 1'b1;
        end
        return r;
    endfunction

    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            rx_lane_fill <= '0;
        end else begin
            for (int l = 0; l < LANES; l++) begin
                rx_lane_fill[l] <= fill_next(rx_lane_fill[l], lane_fill_push[l],
                                             lane_fill_pop[l]);
            end
        end
    end

    default clocking cb @(posedge core_clk);
    endclocking
    default disable iff (!rst_n);

    sequence s_tx_sop_op(logic [1:0] op);
        tx_sop_now && tx_stamp_operation == op;
    endsequence

    sequence s_stamp_return;
        tx_stamp_valid && tx_out_sop;
    endsequence

    property p_nop_ignored;
        s_tx_sop_op(pts_pkg::OP_NONE) |=> !tx_stamp_valid && $stable(tx_stamp_tag);
    endproperty
    a_nop_ignored: assert property (p_nop_ignored) else $error("nop frame stamped");

    property p_rsvd_ignored;
        s_tx_sop_op(pts_pkg::OP_RSVD) |=> !tx_stamp_valid && $stable(tx_stamp_tag);
    endproperty
    a_rsvd_ignored: assert property (p_rsvd_ignored) else $error("reserved op stamped");

    property p_tag_return;
        stamp_req |=> s_stamp_return ##0 (tx_stamp_tag == $past(tx_tag_in));
    endproperty
    a_tag_return: assert property (p_tag_return) else $error("tag not returned");

    property p_valid_cause;
        tx_stamp_valid |-> $past(stamp_req);
    endproperty
    a_valid_cause: assert property (p_valid_cause) else $error("valid without frame");

    property p_tag_stable;
        !stamp_req |=> $stable(tx_stamp_tag) && $stable(tx_stamp);
    endproperty
    a_tag_stable: assert property (p_tag_stable) else $error("tag changed");

    property p_tx_stamp;
        tx_stamp_valid |-> tx_stamp == $past(tx_system_timer);
    endproperty
    a_tx_stamp: assert property (p_tx_stamp) else $error("tx stamp wrong");

    property p_rx_stamp;
        rx_out_sop |-> rx_stamp == $past(rx_system_timer) && rx_out_valid;
    endproperty
    a_rx_stamp: assert property (p_rx_stamp) else $error("rx stamp wrong");

    property p_rx_lane;
        rx_out_sop |-> rx_pcslane == $past(rx_sop_lane_in);
    endproperty
    a_rx_lane: assert property (p_rx_lane) else $error("rx lane wrong");

    property p_tx_lane;
        tx_out_sop |-> tx_pcslane == $past(tx_sop_lane_in);
    endproperty
    a_tx_lane: assert property (p_tx_lane) else $error("tx lane wrong");

    property p_fill_up;
        lane_fill_push[0] && !lane_fill_pop[0] && rx_lane_fill[0] != {FILL_W{1'b1}} |=>
            rx_lane_fill[0] == $past(rx_lane_fill[0]) + 1'b1;
    endproperty
    a_fill_up: assert property (p_fill_up) else $error("fill count wrong");

    property p_fill_hold;
        !lane_fill_push[0] && !lane_fill_pop[0] |=> $stable(rx_lane_fill[0]);
    endproperty
    a_fill_hold: assert property (p_fill_hold) else $error("fill drifted");
endmodule

// [tb_top.sv]
// self-checking bench for the timestamp port with the client model on its far side
// assumes a single 25 MHz core clock and the default port parameters
`timescale 1ns/1ps
module tb_top;
    logic core_clk;
    logic rst_n;
    logic [3:0] lane_fill_push;
    logic [3:0] lane_fill_pop;
    logic tx_in_valid, tx_in_sop, tx_in_eop, tx_upd_chksum_in, rx_in_valid, rx_in_sop;
    logic [63:0] tx_in_data, tx_out_data;
    logic [1:0] tx_stamp_operation, tx_sop_lane_in, rx_sop_lane_in, tx_pcslane, rx_pcslane;
    logic [15:0] tx_tag_in, tx_ts_offset_in, tx_ck_offset_in, tx_stamp_tag;
    logic [79:0] tx_system_timer, rx_system_timer, tx_stamp, rx_stamp;
    logic tx_out_valid, tx_out_sop, tx_out_eop, tx_stamp_valid, rx_out_valid, rx_out_sop;
    logic [3:0][6:0] rx_lane_fill;
    int n_fail;
    int n_tests;

    pts_client client (.core_clk, .tx_in_valid, .tx_in_sop, .tx_in_eop, .tx_in_data,
        .tx_stamp_operation, .tx_tag_in, .tx_upd_chksum_in, .tx_ts_offset_in,
        .tx_ck_offset_in, .tx_sop_lane_in, .tx_system_timer, .rx_in_valid, .rx_in_sop,
        .rx_sop_lane_in, .rx_system_timer);

    pts_port dut (.core_clk, .rst_n, .tx_in_valid, .tx_in_sop, .tx_in_eop, .tx_in_data,
        .tx_stamp_operation, .tx_tag_in, .tx_upd_chksum_in, .tx_ts_offset_in,
        .tx_ck_offset_in, .tx_sop_lane_in, .tx_system_timer, .tx_out_valid, .tx_out_sop,
        .tx_out_eop, .tx_out_data, .tx_stamp_valid, .tx_stamp_tag, .tx_stamp, .tx_pcslane,
        .rx_in_valid, .rx_in_sop, .rx_sop_lane_in, .rx_system_timer, .rx_out_valid,
        .rx_out_sop, .rx_stamp, .rx_pcslane, .lane_fill_push, .lane_fill_pop, .rx_lane_fill);

    always #20 core_clk = ~core_clk;

    task automatic chk(input logic [79:0] got, input logic [79:0] exp);
        n_tests++;
        if (got !== exp) begin
            n_fail++;
            $display("MISMATCH at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic results();
        $display("comparisons %0d, mismatches %0d", n_tests, n_fail);
        if (n_fail == 0 && n_tests > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask

    // frame byte b is b xor a5 unless the stamp or cleared checksum covers it
    function automatic logic [63:0] exp_word(input int w, input logic [1:0] op,
                                             input logic upd, input logic [79:0] s);
        logic [63:0] r;
        int b;
        for (int i = 0; i < 8; i++) begin
            b = 8 * w + i;
            r[8*i +: 8] = 8'(b) ^ 8'ha5;
            if (op == pts_pkg::OP_ONE_STEP && b >= 3 && b < 13) r[8*i +: 8] = s[79-8*(b-3) -: 8];
            if (op == pts_pkg::OP_ONE_STEP && upd && b >= 14) r[8*i +: 8] = 8'h00;
        end
        return r;
    endfunction

    task automatic t_reset();
        chk(80'(tx_stamp_valid), 80'h0);
        chk(80'(rx_lane_fill), 80'h0);
        $display("test reset done");
    endtask

    // back-to-back single-word frames through every operation code
    task automatic t_ops();
        logic [1:0] ops [4];
        logic [79:0] st;
        logic [79:0] ps;
        logic [79:0] es;
        logic [15:0] et;
        logic hit;
        ops = '{pts_pkg::OP_TWO_STEP, pts_pkg::OP_NONE, pts_pkg::OP_RSVD, pts_pkg::OP_ONE_STEP};
        et = 16'h0;
        es = 80'h0;
        for (int k = 0; k <= 5; k++) begin
            if (k < 4) begin
                client.tx_word(1'b1, 1'b1, ops[k], 16'h1111 * 16'(k + 1), 1'b0, 16'h0, 16'h0,
                               2'(k), 64'h0, st);
            end else begin
                client.tx_idle();
            end
            if (k > 0) begin
                hit = k < 5 && (ops[k-1] == pts_pkg::OP_ONE_STEP || ops[k-1] == pts_pkg::OP_TWO_STEP);
                if (hit) begin
                    et = 16'h1111 * 16'(k);
                    es = ps;
                end
                chk(80'(tx_stamp_valid), 80'(hit));
                chk(80'(tx_stamp_tag), 80'(et));
                chk(tx_stamp, es);
                if (k < 5) chk(80'(tx_pcslane), 80'(k - 1));
            end
            ps = st;
        end
        $display("test operation codes done");
    endtask

    // two-word frames: stamp at byte 3, checksum at byte 14
    task automatic t_one_step();
        logic [79:0] st;
        logic [79:0] dummy;
        logic [1:0] op;
        logic upd;
        for (int c = 0; c < 3; c++) begin
            op = (c == 2) ? pts_pkg::OP_TWO_STEP : pts_pkg::OP_ONE_STEP;
            upd = (c != 1);
            client.tx_word(1'b1, 1'b0, op, 16'h5a5a, upd, 16'h3, 16'he, 2'h1,
                           exp_word(0, pts_pkg::OP_NONE, 1'b0, 80'h0), st);
            client.tx_word(1'b0, 1'b1, ~op, 16'ha5a5, ~upd, 16'h0, 16'h0, 2'h2,
                           exp_word(1, pts_pkg::OP_NONE, 1'b0, 80'h0), dummy);
            chk(80'({tx_out_valid, tx_out_sop, tx_out_eop}), 80'h6);
            chk(80'(tx_out_data), 80'(exp_word(0, op, upd, st)));
            client.tx_idle();
            chk(80'({tx_out_valid, tx_out_sop, tx_out_eop}), 80'h5);
            chk(80'(tx_out_data), 80'(exp_word(1, op, upd, st)));
            chk(tx_stamp, st);
        end
        $display("test one-step insertion done");
    endtask

    // back-to-back receive sops on lanes 3..0, then a plain word
    task automatic t_rx();
        logic [79:0] st;
        logic [79:0] ps;
        logic [1:0] pl;
        for (int k = 0; k <= 5; k++) begin
            if (k < 4) client.rx_word(1'b1, 2'(3 - k), st);
            else if (k == 4) client.rx_word(1'b0, 2'h0, st);
            else client.rx_idle();
            if (k > 0) begin
                chk(80'({rx_out_valid, rx_out_sop}), (k < 5) ? 80'h3 : 80'h2);
                chk(rx_stamp, ps);
                chk(80'(rx_pcslane), 80'(pl));
            end
            if (k < 4) begin
                ps = st;
                pl = 2'(3 - k);
            end
        end
        $display("test receive stamp done");
    endtask

    task automatic fill_step(input logic [3:0] push, input logic [3:0] pop);
        @(posedge core_clk);
        #1;
        lane_fill_push = push;
        lane_fill_pop = pop;
    endtask

    // lane 0 saturates, lane 1 push and pop hold, lane 2 counts, lane 3 floors
    task automatic t_fill();
        for (int k = 0; k < 130; k++) fill_step((k < 5) ? 4'h7 : 4'h3, 4'ha);
        fill_step(4'h0, 4'h0);
        chk(80'(rx_lane_fill), 80'({7'h00, 7'h05, 7'h00, 7'h7f}));
        for (int k = 0; k < 3; k++) fill_step(4'h0, 4'h1);
        fill_step(4'h0, 4'h0);
        chk(80'(rx_lane_fill), 80'({7'h00, 7'h05, 7'h00, 7'h7c}));
        for (int k = 0; k < 130; k++) fill_step(4'h0, 4'hf);
        fill_step(4'h0, 4'h0);
        chk(80'(rx_lane_fill), 80'h0);
        $display("test fill levels done");
    endtask

    initial begin
        repeat (20000) @(posedge core_clk);
        n_fail++;
        results();
    end

    initial begin
        core_clk = 1'b0;
        rst_n = 1'b0;
        lane_fill_push = 4'h0;
        lane_fill_pop = 4'h0;
        n_fail = 0;
        n_tests = 0;
        repeat (6) @(posedge core_clk);
        #1;
        rst_n = 1'b1;
        t_reset();
        t_ops();
        t_one_step();
        t_rx();
        t_fill();
        results();
    end
endmodule
